//--- verilog/cgmc_pkg.sv
// Purpose: Shared constants and types of the clock generator mode control
// Assumes: 32-bit AXI4-Lite register bus, 100 MHz bus clock
// Notes:   Each control register is 8 bits wide in the low byte of a word
package cgmc_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0] CGMC_OFS_CTRL_ONE  = 8'h00;
   localparam logic [7:0] CGMC_OFS_CTRL_TWO  = 8'h04;
   localparam logic [7:0] CGMC_OFS_STATUS    = 8'h08;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CGMC_STS_LOCK_LOSS_BIT  = 4;
   localparam int CGMC_STS_CLOCK_LOSS_BIT = 3;

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CGMC_CTRL_ONE_RST = 8'h00;
   localparam logic [7:0] CGMC_CTRL_TWO_RST = 8'h00;

   // ---------------------------------------------------------------
   // Encodings and factors
   // ---------------------------------------------------------------
   localparam logic [1:0] CGMC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CGMC_RESP_SLVERR = 2'h2;
   localparam logic [6:0] CGMC_P_LOW_RANGE  = 7'h40;
   localparam logic [6:0] CGMC_P_HIGH_RANGE = 7'h01;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CGMC_CLK_PERIOD_NS = 10;
   localparam int CGMC_SYNC_TIME_NS  = 40;
   localparam int CGMC_SYNC_CYCLES_I =
      (CGMC_SYNC_TIME_NS + CGMC_CLK_PERIOD_NS - 1) / CGMC_CLK_PERIOD_NS;
   localparam logic [3:0] CGMC_SYNC_CYCLES = 4'(CGMC_SYNC_CYCLES_I);

   typedef enum logic [1:0]
   {
      CGMC_MODE_SELF_CLOCKED  = 2'b00,
      CGMC_MODE_ENGAGED_INT   = 2'b01,
      CGMC_MODE_BYPASSED_EXT  = 2'b10,
      CGMC_MODE_ENGAGED_EXT   = 2'b11
   } cgmc_mode_t;

   typedef struct packed
   {
      logic       osc_high_gain_sel;
      logic       range_high;
      logic       ext_ref_select;
      logic [1:0] clock_mode_request;
      logic       osc_keep_in_off;
      logic       clock_loss_detect_disable;
      logic       reserved0;
   } cgmc_ctrl_one_t;

   typedef struct packed
   {
      logic       lock_loss_reset_en;
      logic [2:0] loop_multiplier;
      logic       clock_loss_reset_en;
      logic [2:0] output_divider;
   } cgmc_ctrl_two_t;

endpackage : cgmc_pkg

//--- verilog/cgmc_top.sv
// Purpose: Control registers and mode control of the clock generator
// Assumes: AXI4-Lite slave, single outstanding write and read
// Notes:   Loop, oscillator and monitors are outside; they report in
`timescale 1ns/1ps

module cgmc_top
   import cgmc_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        off_mode_req,
   input  wire logic        osc_enable_in,
   input  wire logic        ext_ref_freq_ok,
   input  wire logic        lock_lost_evt,
   input  wire logic        clock_lost_evt,
   output logic [1:0]       active_mode_r,
   output logic             clock_static_r,
   output logic             ext_pin_reserved_r,
   output logic             ext_ref_select_r,
   output logic             osc_high_gain_r,
   output logic             osc_enable_r,
   output logic [6:0]       loop_prescale_r,
   output logic [4:0]       loop_mult_n_r,
   output logic [7:0]       output_div_r,
   output logic             loss_detect_en_r,
   output logic             lock_loss_irq_r,
   output logic             lock_loss_rst_r,
   output logic             clock_loss_irq_r,
   output logic             clock_loss_rst_r
);

   // ---------------------------------------------------------------
   // Decoding functions
   // ---------------------------------------------------------------
   function automatic logic [4:0] mult_factor(input logic [2:0] code);
      mult_factor = 5'(({2'h0, code} + 5'h02) << 1);
   endfunction : mult_factor

   function automatic logic [7:0] div_factor(input logic [2:0] code);
      div_factor = 8'(8'h01 << code);
   endfunction : div_factor

   function automatic logic [3:0] count_down(input logic [3:0] cnt);
      count_down = (cnt == 4'h0) ? 4'h0 : 4'(cnt - 4'h1);
   endfunction : count_down

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   cgmc_ctrl_one_t ctrl_one_r;
   cgmc_ctrl_two_t ctrl_two_r;
   logic           first_write_done_r;
   logic [3:0]     mode_cnt_r;
   logic           mode_pend_r;
   logic [3:0]     mult_cnt_r;
   logic           mult_pend_r;
   logic [3:0]     div_cnt_r;
   logic           div_pend_r;
   logic [2:0]     mult_applied_r;
   logic [2:0]     div_applied_r;
   logic           ext_ref_stable_r;
   logic           lock_loss_flag_r;
   logic           clock_loss_flag_r;
   logic [7:0]     awaddr_r;
   logic           aw_held_r;
   logic [31:0]    wdata_r;
   logic [3:0]     wstrb_r;
   logic           w_held_r;

   logic           wr_fire;
   logic           wr_one;
   logic           wr_two;
   logic           wr_sts;
   logic           wr_hit;
   logic [7:0]     wbyte;
   cgmc_ctrl_one_t wone;
   cgmc_ctrl_two_t wtwo;
   logic           mode_take;
   logic           ext_mode_now;
   logic           osc_keep;

   // ---------------------------------------------------------------
   // AXI4-Lite write channel
   // ---------------------------------------------------------------
   assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_hit  = wr_fire && wstrb_r[0];
   assign wbyte   = wdata_r[7:0];
   assign wone    = cgmc_ctrl_one_t'(wbyte);
   assign wtwo    = cgmc_ctrl_two_t'(wbyte);
   assign wr_one  = wr_hit && (awaddr_r == CGMC_OFS_CTRL_ONE);
   assign wr_two  = wr_hit && (awaddr_r == CGMC_OFS_CTRL_TWO);
   assign wr_sts  = wr_hit && (awaddr_r == CGMC_OFS_STATUS);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r     <= 1'b0;
         awaddr_r      <= 8'h00;
         s_axi_awready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= 1'b0;
         if (wr_fire)
            aw_held_r <= 1'b0;
         else if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr[7:2], 2'b00};
         end
         else if (s_axi_awvalid && !aw_held_r)
            s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r     <= 1'b0;
         wdata_r      <= 32'h0000_0000;
         wstrb_r      <= 4'h0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_wready <= 1'b0;
         if (wr_fire)
            w_held_r <= 1'b0;
         else if (s_axi_wvalid && s_axi_wready)
         begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         else if (s_axi_wvalid && !w_held_r)
            s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= CGMC_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (awaddr_r == CGMC_OFS_CTRL_ONE ||
                          awaddr_r == CGMC_OFS_CTRL_TWO ||
                          awaddr_r == CGMC_OFS_STATUS)
                         ? CGMC_RESP_OKAY : CGMC_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ---------------------------------------------------------------
   // AXI4-Lite read channel
   // ---------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= CGMC_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_rvalid)
         begin
            if (s_axi_rready)
               s_axi_rvalid <= 1'b0;
         end
         else if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= CGMC_RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'b00})
               CGMC_OFS_CTRL_ONE:
                  s_axi_rdata <= {24'h00_0000, ctrl_one_r};
               CGMC_OFS_CTRL_TWO:
                  s_axi_rdata <= {24'h00_0000, ctrl_two_r};
               CGMC_OFS_STATUS:
                  s_axi_rdata <= {24'h00_0000, active_mode_r,
                                  ext_ref_select_r, lock_loss_flag_r,
                                  clock_loss_flag_r,
                                  mode_pend_r | mult_pend_r | div_pend_r,
                                  ext_ref_stable_r, clock_static_r};
               default:
               begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= CGMC_RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_arvalid)
            s_axi_arready <= 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Control register one
   // ---------------------------------------------------------------
   // Mode write accepted only when idle and not asking for an
   // unreserved external pin
   assign mode_take = wr_one && !mode_pend_r &&
                      (!first_write_done_r || ext_pin_reserved_r ||
                       !wone.clock_mode_request[1]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_one_r         <= cgmc_ctrl_one_t'(CGMC_CTRL_ONE_RST);
         first_write_done_r <= 1'b0;
         ext_pin_reserved_r <= 1'b0;
      end
      else if (wr_one)
      begin
         first_write_done_r <= 1'b1;
         if (!first_write_done_r)
         begin
            ctrl_one_r.osc_high_gain_sel <= wone.osc_high_gain_sel;
            ctrl_one_r.range_high        <= wone.range_high;
            ctrl_one_r.ext_ref_select    <= wone.ext_ref_select;
            ext_pin_reserved_r <= wone.clock_mode_request[1];
         end
         if (mode_take)
            ctrl_one_r.clock_mode_request <= wone.clock_mode_request;
         ctrl_one_r.osc_keep_in_off           <= wone.osc_keep_in_off;
         ctrl_one_r.clock_loss_detect_disable <=
            wone.clock_loss_detect_disable;
      end
   end

   // ---------------------------------------------------------------
   // Mode update and switching
   // ---------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_pend_r   <= 1'b0;
         mode_cnt_r    <= 4'h0;
         active_mode_r <= CGMC_MODE_SELF_CLOCKED;
      end
      else if (mode_take)
      begin
         mode_pend_r <= 1'b1;
         mode_cnt_r  <= CGMC_SYNC_CYCLES;
      end
      else if (mode_pend_r && !off_mode_req)
      begin
         mode_cnt_r <= count_down(mode_cnt_r);
         // Old clock kept until the external reference is stable when switching to bypassed external
         if (mode_cnt_r == 4'h0 &&
             (ctrl_one_r.clock_mode_request != CGMC_MODE_BYPASSED_EXT ||
              ext_ref_stable_r))
         begin
            active_mode_r <= ctrl_one_r.clock_mode_request;
            mode_pend_r   <= 1'b0;
         end
      end
   end

   // Off mode freezes the output, stalls a pending mode switch and leaves the oscillator enabled only where osc_keep holds; the request field is untouched
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clock_static_r <= 1'b0;
      else
         clock_static_r <= off_mode_req;
   end

   // ---------------------------------------------------------------
   // Oscillator and reference control
   // ---------------------------------------------------------------
   assign ext_mode_now = active_mode_r[1];

   always_comb
   begin
      if (ctrl_one_r.osc_high_gain_sel && ctrl_one_r.range_high)
         osc_keep = 1'b1;
      else if (ctrl_one_r.osc_keep_in_off)
         osc_keep = ctrl_one_r.clock_mode_request[1] &&
                    ctrl_one_r.ext_ref_select;
      else
         osc_keep = osc_enable_in && ctrl_one_r.ext_ref_select &&
                    ctrl_one_r.clock_mode_request ==
                    CGMC_MODE_BYPASSED_EXT;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         osc_enable_r     <= 1'b0;
         osc_high_gain_r  <= 1'b0;
         ext_ref_select_r <= 1'b0;
         loop_prescale_r  <= CGMC_P_HIGH_RANGE;
         ext_ref_stable_r <= 1'b0;
         loss_detect_en_r <= 1'b0;
      end
      else
      begin
         osc_high_gain_r  <= ctrl_one_r.osc_high_gain_sel;
         ext_ref_select_r <= ext_pin_reserved_r &&
                             ctrl_one_r.ext_ref_select;
         if (!ext_pin_reserved_r || !ctrl_one_r.ext_ref_select)
            osc_enable_r <= 1'b0;
         else if (off_mode_req)
            osc_enable_r <= osc_keep;
         else
            osc_enable_r <= 1'b1;
         // Range only shapes the prescaler on an external reference
         if (ext_mode_now)
            loop_prescale_r <= ctrl_one_r.range_high
                               ? CGMC_P_HIGH_RANGE
                               : CGMC_P_LOW_RANGE;
         else
            loop_prescale_r <= CGMC_P_HIGH_RANGE;
         ext_ref_stable_r <= ext_pin_reserved_r && ext_ref_freq_ok;
         loss_detect_en_r <= !ctrl_one_r.clock_loss_detect_disable;
      end
   end

   // ---------------------------------------------------------------
   // Control register two and loop factors
   // ---------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_two_r     <= cgmc_ctrl_two_t'(CGMC_CTRL_TWO_RST);
         mult_pend_r    <= 1'b0;
         mult_cnt_r     <= 4'h0;
         div_pend_r     <= 1'b0;
         div_cnt_r      <= 4'h0;
         mult_applied_r <= 3'h0;
         div_applied_r  <= 3'h0;
      end
      else
      begin
         mult_cnt_r <= count_down(mult_cnt_r);
         div_cnt_r  <= count_down(div_cnt_r);
         if (mult_pend_r && mult_cnt_r == 4'h0)
         begin
            mult_pend_r    <= 1'b0;
            mult_applied_r <= ctrl_two_r.loop_multiplier;
         end
         if (div_pend_r && div_cnt_r == 4'h0)
         begin
            div_pend_r    <= 1'b0;
            div_applied_r <= ctrl_two_r.output_divider;
         end
         if (wr_two)
         begin
            ctrl_two_r.lock_loss_reset_en  <= wtwo.lock_loss_reset_en;
            ctrl_two_r.clock_loss_reset_en <= wtwo.clock_loss_reset_en;
            if (!mult_pend_r)
            begin
               ctrl_two_r.loop_multiplier <= wtwo.loop_multiplier;
               mult_pend_r <= 1'b1;
               mult_cnt_r  <= CGMC_SYNC_CYCLES;
            end
            if (!div_pend_r)
            begin
               ctrl_two_r.output_divider <= wtwo.output_divider;
               div_pend_r <= 1'b1;
               div_cnt_r  <= CGMC_SYNC_CYCLES;
            end
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         loop_mult_n_r <= mult_factor(3'h0);
         output_div_r  <= div_factor(3'h0);
      end
      else
      begin
         loop_mult_n_r <= mult_factor(mult_applied_r);
         output_div_r  <= div_factor(div_applied_r);
      end
   end

   // ---------------------------------------------------------------
   // Loss flags and requests
   // ---------------------------------------------------------------
   // A new loss in the clearing cycle keeps the flag set
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lock_loss_flag_r  <= 1'b0;
         clock_loss_flag_r <= 1'b0;
      end
      else
      begin
         if (lock_lost_evt)
            lock_loss_flag_r <= 1'b1;
         else if (wr_sts && wbyte[CGMC_STS_LOCK_LOSS_BIT])
            lock_loss_flag_r <= 1'b0;
         if (clock_lost_evt && loss_detect_en_r)
            clock_loss_flag_r <= 1'b1;
         else if (wr_sts && wbyte[CGMC_STS_CLOCK_LOSS_BIT])
            clock_loss_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lock_loss_irq_r  <= 1'b0;
         lock_loss_rst_r  <= 1'b0;
         clock_loss_irq_r <= 1'b0;
         clock_loss_rst_r <= 1'b0;
      end
      else
      begin
         lock_loss_irq_r  <= lock_loss_flag_r &&
                             !ctrl_two_r.lock_loss_reset_en;
         lock_loss_rst_r  <= lock_loss_flag_r &&
                             ctrl_two_r.lock_loss_reset_en;
         clock_loss_irq_r <= clock_loss_flag_r &&
                             !ctrl_two_r.clock_loss_reset_en;
         clock_loss_rst_r <= clock_loss_flag_r &&
                             ctrl_two_r.clock_loss_reset_en;
      end
   end

endmodule : cgmc_top

//--- verification/cgmc_checker.sv
// Purpose: Port-level checks of the clock generator mode control
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound onto cgmc_top, watches outputs and the off and reference inputs
`timescale 1ns/1ps
module cgmc_checker
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire logic       off_mode_req,
   input wire logic       ext_ref_freq_ok,
   input wire logic [1:0] active_mode_r,
   input wire logic       ext_pin_reserved_r,
   input wire logic       ext_ref_select_r,
   input wire logic [6:0] loop_prescale_r,
   input wire logic [4:0] loop_mult_n_r,
   input wire logic [7:0] output_div_r,
   input wire logic       lock_loss_irq_r,
   input wire logic       lock_loss_rst_r,
   input wire logic       clock_loss_irq_r,
   input wire logic       clock_loss_rst_r
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_pre_vals;
      loop_prescale_r inside {7'h01, 7'h40};
   endproperty
   a_pre_vals: assert property (p_pre_vals)
      else $error("prescale not 1 or 64");
   property p_pre_int;
      (!active_mode_r[1]) [*3] |-> loop_prescale_r == 7'h01;
   endproperty
   a_pre_int: assert property (p_pre_int)
      else $error("range acts in internal mode");
   property p_mult;
      !loop_mult_n_r[0] && loop_mult_n_r >= 5'h04 && loop_mult_n_r <= 5'h12;
   endproperty
   a_mult: assert property (p_mult)
      else $error("multiplier outside 4..18 even");
   property p_div;
      $onehot(output_div_r);
   endproperty
   a_div: assert property (p_div)
      else $error("divider not a power of two");
   property p_byp;
      $changed(active_mode_r) && active_mode_r == 2'h2 |-> $past(ext_ref_freq_ok);
   endproperty
   a_byp: assert property (p_byp)
      else $error("bypass entered without stable reference");
   property p_ext;
      active_mode_r[1] |-> ext_pin_reserved_r;
   endproperty
   a_ext: assert property (p_ext)
      else $error("external mode without reserved pin");
   property p_refsel;
      ext_ref_select_r |-> ext_pin_reserved_r;
   endproperty
   a_refsel: assert property (p_refsel)
      else $error("reference select without reserved pin");
   property p_off;
      off_mode_req [*2] |-> $stable(active_mode_r);
   endproperty
   a_off: assert property (p_off)
      else $error("mode changed in off mode");
   property p_lock;
      !(lock_loss_irq_r && lock_loss_rst_r);
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock loss irq and reset together");
   property p_clk;
      !(clock_loss_irq_r && clock_loss_rst_r);
   endproperty
   a_clk: assert property (p_clk)
      else $error("clock loss irq and reset together");
endmodule : cgmc_checker
bind cgmc_top cgmc_checker u_cgmc_checker
(
   .aclk, .aresetn, .off_mode_req, .ext_ref_freq_ok, .active_mode_r,
   .ext_pin_reserved_r, .ext_ref_select_r, .loop_prescale_r,
   .loop_mult_n_r, .output_div_r, .lock_loss_irq_r, .lock_loss_rst_r,
   .clock_loss_irq_r, .clock_loss_rst_r
);

//--- verification/cgmc_ref_source.sv
// Purpose: Behavioural external crystal or clock source
// Assumes: Source starts once the pin is reserved
// Notes:   START_CYCLES sets a prompt or a slow start-up
`timescale 1ns/1ps
module cgmc_ref_source
#(
   parameter int START_CYCLES = 8
)
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic ext_pin_reserved_r,
   output logic      ext_ref_freq_ok
);
   int cnt_r;
   // Unreserved pin has nothing behind it, so it never qualifies
   always_ff @(posedge aclk)
      if (!aresetn || !ext_pin_reserved_r)
         cnt_r <= 0;
      else if (cnt_r < START_CYCLES)
         cnt_r <= cnt_r + 1;
   assign ext_ref_freq_ok = (cnt_r == START_CYCLES);
endmodule : cgmc_ref_source

//--- verification/tb_top.sv
// Purpose: Self-checking bench of the clock generator mode control
// Assumes: AXI4-Lite master tasks, one transfer at a time
// Notes:   Slow reference source so the bypass wait is visible
`timescale 1ns/1ps
module tb_top;
   import cgmc_pkg::*;
   logic        aclk = 1'h0, aresetn = 1'h0, off_mode_req = 1'h0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, rdat, s_axi_rdata;
   logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
   logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
   logic        s_axi_rready = 1'h0, lock_lost_evt = 1'h0;
   logic        clock_lost_evt = 1'h0, osc_enable_in = 1'h0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, active_mode_r;
   logic [6:0]  loop_prescale_r;
   logic [4:0]  loop_mult_n_r;
   logic [7:0]  output_div_r;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, ext_pin_reserved_r, ext_ref_select_r;
   logic        osc_high_gain_r, osc_enable_r, ext_ref_freq_ok;
   logic        lock_loss_irq_r, lock_loss_rst_r, loss_detect_en_r;
   logic        clock_loss_irq_r, clock_loss_rst_r, clock_static_r;
   int          err_count = 0, tests_run = 0;
   cgmc_top u_cgmc_top
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .off_mode_req, .osc_enable_in,
      .ext_ref_freq_ok, .lock_lost_evt, .clock_lost_evt, .active_mode_r,
      .clock_static_r, .ext_pin_reserved_r, .ext_ref_select_r,
      .osc_high_gain_r, .osc_enable_r, .loop_prescale_r, .loop_mult_n_r,
      .output_div_r, .loss_detect_en_r, .lock_loss_irq_r,
      .lock_loss_rst_r, .clock_loss_irq_r, .clock_loss_rst_r
   );
   cgmc_ref_source #(.START_CYCLES(40)) u_cgmc_ref_source
   (
      .aclk, .aresetn, .ext_pin_reserved_r, .ext_ref_freq_ok
   );
   always #5 aclk = ~aclk;
   task automatic stop_test;
      $display("Checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : stop_test
   task automatic chk(string n, logic [31:0] e, logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic need(logic c, string n);
      if (c !== 1'h1)
      begin
         chk(n, 1, 0);
         stop_test();
      end
   endtask : need
   task automatic tick(int n);
      repeat (n) @(posedge aclk);
   endtask : tick
   task automatic do_reset;
      aresetn <= 1'h0;
      tick(5);
      aresetn <= 1'h1;
   endtask : do_reset
   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      repeat (50)
      begin
         @(posedge aclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid)
            break;
      end
      need(s_axi_bvalid, "bvalid");
      s_axi_bready <= 1'h0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [1:0] rsp);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      repeat (50)
      begin
         @(posedge aclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid)
            break;
      end
      need(s_axi_rvalid, "rvalid");
      rdat = s_axi_rdata;
      chk("rresp", rsp, s_axi_rresp);
      s_axi_rready <= 1'h0;
   endtask : rd
   task automatic wait_mode(logic [1:0] m);
      repeat (100)
      begin
         @(posedge aclk);
         if (active_mode_r === m)
            break;
      end
      chk("mode", m, active_mode_r);
      if (active_mode_r !== m)
         stop_test();
   endtask : wait_mode
   task automatic t_first;
      chk("mult rst", 4, loop_mult_n_r);
      chk("div rst", 1, output_div_r);
      rd(8'h0c, CGMC_RESP_SLVERR);
      chk("err data", 0, rdat);
      wr(CGMC_OFS_CTRL_ONE, 32'h0000_00b0);
      tick(10);
      chk("gain", 1, osc_high_gain_r);
      chk("refsel", 1, ext_ref_select_r);
      chk("mode wait", 0, active_mode_r);
      wait_mode(2'h2);
      tick(3);
      chk("prescale", 64, loop_prescale_r);
      off_mode_req <= 1'h1;
      osc_enable_in <= 1'h1;
      tick(3);
      chk("osc enable", 1, osc_enable_r);
      off_mode_req <= 1'h0;
      osc_enable_in <= 1'h0;
      wr(CGMC_OFS_CTRL_ONE, 32'h0000_0078);
      rd(CGMC_OFS_CTRL_ONE, CGMC_RESP_OKAY);
      chk("ctrl one", 32'h0000_00b8, rdat);
      wait_mode(2'h3);
      chk("osc run", 1, osc_enable_r);
      off_mode_req <= 1'h1;
      wr(CGMC_OFS_CTRL_ONE, 32'h0000_00a8);
      wr(CGMC_OFS_CTRL_ONE, 32'h0000_00a0);
      tick(10);
      chk("off mode", 3, active_mode_r);
      chk("static", 1, clock_static_r);
      chk("osc off", 0, osc_enable_r);
      off_mode_req <= 1'h0;
      wait_mode(2'h1);
   endtask : t_first
   task automatic t_lock0;
      do_reset();
      wr(CGMC_OFS_CTRL_ONE, 32'h0000_0008);
      wait_mode(2'h1);
      wr(CGMC_OFS_CTRL_ONE, 32'h0000_0018);
      tick(20);
      chk("no ext", 1, active_mode_r);
      chk("pin", 0, ext_pin_reserved_r);
   endtask : t_lock0
   task automatic t_two;
      for (int i = 0; i < 8; i++)
      begin
         wr(CGMC_OFS_CTRL_TWO, {25'h0, i[2:0], 1'h0, i[2:0]});
         tick(10);
         chk("mult", 2 * i + 4, loop_mult_n_r);
         chk("div", 1 << i, output_div_r);
      end
   endtask : t_two
   task automatic pulse;
      @(posedge aclk);
      lock_lost_evt <= 1'h1;
      clock_lost_evt <= 1'h1;
      @(posedge aclk);
      lock_lost_evt <= 1'h0;
      clock_lost_evt <= 1'h0;
      tick(5);
   endtask : pulse
   task automatic t_loss;
      for (int e = 0; e < 2; e++)
      begin
         wr(CGMC_OFS_CTRL_TWO, e ? 32'h0000_0088 : 32'h0000_0000);
         pulse();
         chk("lock irq", 1 - e, lock_loss_irq_r);
         chk("lock rst", e, lock_loss_rst_r);
         chk("clk irq", 1 - e, clock_loss_irq_r);
         chk("clk rst", e, clock_loss_rst_r);
         wr(CGMC_OFS_STATUS, 32'h0000_0018);
         tick(3);
         chk("lock clr", 0, lock_loss_irq_r | lock_loss_rst_r);
      end
      wr(CGMC_OFS_CTRL_ONE, 32'h0000_0002);
      pulse();
      chk("loss off", 0, clock_loss_rst_r);
      chk("detect", 0, loss_detect_en_r);
   endtask : t_loss
   initial
   begin
      do_reset();
      t_first();
      t_lock0();
      t_two();
      t_loss();
      stop_test();
   end
endmodule : tb_top
